// [shared/degc_pkg.sv]
`default_nettype none

package degc_pkg;

    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // ---------------------------------------------------------------
    // control field positions
    // ---------------------------------------------------------------
    localparam int unsigned CTRL_IN_REG_BIT   = 0;
    localparam int unsigned CTRL_OUT_REG_BIT  = 1;
    localparam int unsigned CTRL_OE_REG_BIT   = 2;
    localparam int unsigned CTRL_DUAL_BIT     = 3;
    localparam int unsigned CTRL_RESYNC_BIT   = 4;
    localparam int unsigned CTRL_PULL_DN_BIT  = 5;
    localparam int unsigned CTRL_CFG_DONE_BIT = 6;
    localparam int unsigned CTRL_W            = 7;
    localparam logic [6:0]  CTRL_RESET        = 7'h00;

    // ---------------------------------------------------------------
    // status field positions
    // ---------------------------------------------------------------
    localparam int unsigned STAT_PAD_BIT      = 0;
    localparam int unsigned STAT_OVERRUN_BIT  = 1;
    localparam int unsigned STAT_DUAL_OK_BIT  = 2;
    localparam int unsigned STAT_DIFF_BIT     = 3;
    localparam int unsigned STAT_LEVEL_LSB    = 4;

    // ---------------------------------------------------------------
    // data path
    // ---------------------------------------------------------------
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned WORD_W     = 2;

endpackage

`default_nettype wire

// [logic/degc_cell.sv]
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module degc_fifo #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_i,
    input  wire logic [WIDTH-1:0]           in_data_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    output logic [WIDTH-1:0]                out_data_o,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [$clog2(DEPTH+1)-1:0]      level_o
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [LW-1:0]    count;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && (count != LW'(DEPTH));
    assign pop         = out_ready_i && (count != '0);
    assign in_ready_o  = (count != LW'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign level_o     = count;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : PW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : PW'(rd_ptr + 1'b1);
            end
            count <= LW'(count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
        end
    end
endmodule // degc_fifo

module degc_cell #(
    parameter bit          DUAL_CAPABLE = 1'b1,
    parameter bit          DIFF_PAIR    = 1'b0,
    parameter int unsigned FIFO_DEPTH   = degc_pkg::FIFO_DEPTH
) (
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_i,
    input  wire logic [degc_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                         avs_read_i,
    input  wire logic                         avs_write_i,
    input  wire logic [degc_pkg::DATA_W-1:0]  avs_writedata_i,
    output logic      [degc_pkg::DATA_W-1:0]  avs_readdata_o,
    output logic                              avs_waitrequest_o,
    input  wire logic                         ingress_reg_clk_i,
    input  wire logic                         egress_reg_clk_i,
    input  wire logic                         tx_bit_rise_i,
    input  wire logic                         tx_bit_fall_i,
    input  wire logic                         drive_enable_i,
    input  wire logic                         rx_ready_i,
    output logic                              rx_bit_rise_o,
    output logic                              rx_bit_fall_o,
    output logic                              rx_valid_o,
    output logic                              bypass_input_tap_o,
    input  wire logic                         pad_in_i,
    output logic                              pad_out_o,
    output logic                              pad_oe_n_o,
    output logic                              pad_pull_up_o,
    output logic                              pad_pull_down_o
);
    import degc_pkg::*;

    localparam int unsigned LW = $clog2(FIFO_DEPTH+1);
    localparam bit DUAL_OK = DUAL_CAPABLE && !DIFF_PAIR;

    logic [CTRL_W-1:0] ctrl;
    logic              overrun;
    logic              in_clk_q;
    logic              out_clk_q;
    logic              cap_rise;
    logic              cap_fall_held;
    logic [WORD_W-1:0] cap_word;
    logic              cap_valid;
    logic              tx_fall_hold;
    logic              oe_reg;
    logic              fifo_in_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic              fifo_out_valid;
    logic [LW-1:0]     fifo_level;
    logic              fifo_pop;
    logic              in_rise_ev;
    logic              in_fall_ev;
    logic              out_rise_ev;
    logic              out_fall_ev;
    logic              dual_on;
    logic              resync_on;
    logic              cfg_done;
    logic              cap_event;
    logic [WORD_W-1:0] cap_new;
    logic              bus_ack;
    logic              oe_eff;
    logic [DATA_W-1:0] status_word;

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    assign dual_on   = DUAL_OK && ctrl[CTRL_DUAL_BIT];
    assign resync_on = dual_on && ctrl[CTRL_RESYNC_BIT];
    assign cfg_done  = ctrl[CTRL_CFG_DONE_BIT];

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    assign bus_ack = (avs_read_i || avs_write_i) && avs_waitrequest_o;

    always_comb begin
        status_word                           = '0;
        status_word[STAT_PAD_BIT]             = pad_in_i;
        status_word[STAT_OVERRUN_BIT]         = overrun;
        status_word[STAT_DUAL_OK_BIT]         = DUAL_OK;
        status_word[STAT_DIFF_BIT]            = DIFF_PAIR;
        status_word[STAT_LEVEL_LSB +: LW]     = fifo_level;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !bus_ack;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= '0;
        end else if (bus_ack && avs_read_i) begin
            unique case (avs_address_i)
                CTRL_OFFSET:   avs_readdata_o <= DATA_W'(ctrl);
                STATUS_OFFSET: avs_readdata_o <= status_word;
                default:       avs_readdata_o <= '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
        end else if (bus_ack && avs_write_i && avs_address_i == CTRL_OFFSET) begin
            ctrl <= avs_writedata_i[CTRL_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // clock edge detection
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            in_clk_q  <= 1'b0;
            out_clk_q <= 1'b0;
        end else begin
            in_clk_q  <= ingress_reg_clk_i;
            out_clk_q <= egress_reg_clk_i;
        end
    end

    assign in_rise_ev  = ingress_reg_clk_i && !in_clk_q;
    assign in_fall_ev  = !ingress_reg_clk_i && in_clk_q;
    assign out_rise_ev = egress_reg_clk_i && !out_clk_q;
    assign out_fall_ev = !egress_reg_clk_i && out_clk_q;

    // ---------------------------------------------------------------
    // input capture, pad sampled whatever the driver does
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cap_rise      <= 1'b0;
            cap_fall_held <= 1'b0;
        end else if (ctrl[CTRL_IN_REG_BIT]) begin
            if (in_rise_ev) begin
                cap_rise <= pad_in_i;
            end
            if (in_fall_ev && dual_on) begin
                cap_fall_held <= pad_in_i;
            end
        end
    end

    always_comb begin
        cap_event = 1'b0;
        cap_new   = '0;
        if (ctrl[CTRL_IN_REG_BIT]) begin
            if (!dual_on) begin
                cap_event = in_rise_ev;
                cap_new   = {1'b0, pad_in_i};
            end else if (resync_on) begin
                cap_event = in_rise_ev;
                cap_new   = {cap_fall_held, pad_in_i};
            end else begin
                cap_event = in_rise_ev || in_fall_ev;
                cap_new   = in_rise_ev ? {cap_fall_held, pad_in_i} : {pad_in_i, cap_rise};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cap_word  <= '0;
            cap_valid <= 1'b0;
        end else if (cap_event && (!cap_valid || fifo_in_ready)) begin
            cap_word  <= cap_new;
            cap_valid <= 1'b1;
        end else if (fifo_in_ready) begin
            cap_valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            overrun <= 1'b0;
        end else if (cap_event && cap_valid && !fifo_in_ready) begin
            overrun <= 1'b1;
        end else if (bus_ack && avs_write_i && avs_address_i == STATUS_OFFSET
                     && avs_writedata_i[STAT_OVERRUN_BIT]) begin
            overrun <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // capture fifo and core delivery
    // ---------------------------------------------------------------
    assign fifo_pop = fifo_out_valid && (!rx_valid_o || rx_ready_i);

    degc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (cap_word),
        .in_valid_i  (cap_valid),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .level_o     (fifo_level)
    );

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_valid_o    <= 1'b0;
            rx_bit_rise_o <= 1'b0;
            rx_bit_fall_o <= 1'b0;
        end else if (fifo_pop) begin
            rx_valid_o    <= 1'b1;
            rx_bit_rise_o <= fifo_out_data[0];
            rx_bit_fall_o <= fifo_out_data[1];
        end else if (rx_ready_i) begin
            rx_valid_o    <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bypass_input_tap_o <= 1'b0;
        end else begin
            bypass_input_tap_o <= ctrl[CTRL_IN_REG_BIT] ? 1'b0 : pad_in_i;
        end
    end

    // ---------------------------------------------------------------
    // output and drive enable
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pad_out_o    <= 1'b0;
            tx_fall_hold <= 1'b0;
        end else if (!ctrl[CTRL_OUT_REG_BIT]) begin
            pad_out_o    <= tx_bit_rise_i;
        end else if (out_rise_ev) begin
            pad_out_o    <= tx_bit_rise_i;
            tx_fall_hold <= tx_bit_fall_i;
        end else if (out_fall_ev && dual_on) begin
            pad_out_o    <= resync_on ? tx_fall_hold : tx_bit_fall_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            oe_reg <= 1'b0;
        end else if (!ctrl[CTRL_OE_REG_BIT] || out_rise_ev) begin
            oe_reg <= drive_enable_i;
        end
    end

    assign oe_eff = cfg_done && oe_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pad_oe_n_o      <= 1'b1;
            pad_pull_up_o   <= 1'b1;
            pad_pull_down_o <= 1'b0;
        end else begin
            pad_oe_n_o      <= !oe_eff;
            pad_pull_up_o   <= !cfg_done || (!oe_eff && (DIFF_PAIR || !ctrl[CTRL_PULL_DN_BIT]));
            pad_pull_down_o <= cfg_done && !oe_eff && !DIFF_PAIR && ctrl[CTRL_PULL_DN_BIT];
        end
    end
endmodule // degc_cell

`default_nettype wire

// [test/degc_cell_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module degc_cell_monitor #(
    parameter bit DUAL_CAPABLE = 1'b1,
    parameter bit DIFF_PAIR    = 1'b0
) (
    input wire logic                        ref_clk_i,
    input wire logic                        rst_i,
    input wire logic [degc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic                        avs_read_i,
    input wire logic                        avs_write_i,
    input wire logic [degc_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic                        avs_waitrequest_o,
    input wire logic                        tx_bit_rise_i,
    input wire logic                        rx_ready_i,
    input wire logic                        rx_valid_o,
    input wire logic                        rx_bit_rise_o,
    input wire logic                        rx_bit_fall_o,
    input wire logic                        bypass_input_tap_o,
    input wire logic                        pad_in_i,
    input wire logic                        pad_out_o,
    input wire logic                        pad_oe_n_o,
    input wire logic                        pad_pull_up_o,
    input wire logic                        pad_pull_down_o
);
    import degc_pkg::*;

    logic [6:0] ctrl;

    // ------------------------------
    // mirror of the control register
    // ------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl <= 7'h00;
        end else if (avs_write_i && avs_waitrequest_o && avs_address_i == CTRL_OFFSET) begin
            ctrl <= avs_writedata_i[6:0];
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    cfg_tristate_a: assert property (!ctrl[6] && !$past(ctrl[6]) |=> pad_oe_n_o && pad_pull_up_o)
        else $error("pad not released before configuration");
    pull_select_a: assert property (pad_pull_down_o |-> !DIFF_PAIR && !pad_pull_up_o && pad_oe_n_o)
        else $error("pull-down where not allowed");
    drive_nopull_a: assert property (!pad_oe_n_o |-> !pad_pull_up_o && !pad_pull_down_o)
        else $error("pull active while driving");
    single_edge_a: assert property (rx_valid_o && rx_bit_fall_o |-> DUAL_CAPABLE && !DIFF_PAIR && ctrl[3])
        else $error("falling capture on single-edge cell");
    bypass_follow_a: assert property (!ctrl[0] && !$past(ctrl[0]) |=> bypass_input_tap_o == $past(pad_in_i))
        else $error("bypass tap not following pad");
    bypass_quiet_a: assert property (ctrl[0] && $past(ctrl[0]) |=> !bypass_input_tap_o)
        else $error("bypass tap active with input register");
    out_direct_a: assert property (!ctrl[1] && !$past(ctrl[1]) |=> pad_out_o == $past(tx_bit_rise_i))
        else $error("pad output not following core bit");
    rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_bit_rise_o)
        && $stable(rx_bit_fall_o))
        else $error("capture word changed before taken");

endmodule // degc_cell_monitor

bind degc_cell degc_cell_monitor #(.DUAL_CAPABLE(DUAL_CAPABLE), .DIFF_PAIR(DIFF_PAIR)) u_mon (
    .ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o,
    .tx_bit_rise_i, .rx_ready_i, .rx_valid_o, .rx_bit_rise_o, .rx_bit_fall_o, .bypass_input_tap_o,
    .pad_in_i, .pad_out_o, .pad_oe_n_o, .pad_pull_up_o, .pad_pull_down_o
);

`default_nettype wire

// [test/degc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

module degc_core_model (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic stall_i,
    output logic      ingress_clk_o,
    output logic      egress_clk_o,
    output logic      tx_rise_o,
    output logic      tx_fall_o,
    output logic      drive_en_o,
    output logic      rx_ready_o
);
    logic [1:0]  ph = 2'h0;
    logic [31:0] r;
    int          seed = 48742;

    // ------------------------------
    // core clocks, data and ready
    // ------------------------------
    always @(posedge ref_clk_i) begin
        r = $random(seed);
        if (rst_i) begin
            {ingress_clk_o, egress_clk_o, tx_rise_o, tx_fall_o, drive_en_o, rx_ready_o} <= 6'h00;
            ph <= 2'h0;
        end else begin
            rx_ready_o <= !stall_i && r[4:3] != 2'h0;
            if (run_i) begin
                ph <= ph + 2'h1;
                if (ph == 2'h0) begin
                    ingress_clk_o <= !ingress_clk_o;
                    egress_clk_o  <= !egress_clk_o;
                end
                if (ph == 2'h2) begin
                    tx_rise_o  <= r[0];
                    tx_fall_o  <= r[1];
                    drive_en_o <= r[2];
                end
            end
        end
    end

endmodule // degc_core_model

`default_nettype wire

// [test/test_dual_edge_gpio_cell.sv]
`timescale 1ns/1ps
`default_nettype none

module test_dual_edge_gpio_cell;
    import degc_pkg::*;

    logic              ref_clk_i = 1'h0, rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0, pad_in_i = 1'h0;
    logic [ADDR_W-1:0] avs_address_i = 4'h0;
    logic [DATA_W-1:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
    logic              avs_waitrequest_o, ingress_reg_clk_i, egress_reg_clk_i, tx_bit_rise_i, tx_bit_fall_i;
    logic              drive_enable_i, rx_ready_i, rx_bit_rise_o, rx_bit_fall_o, rx_valid_o, bypass_input_tap_o;
    logic              pad_out_o, pad_oe_n_o, pad_pull_up_o, pad_pull_down_o;
    logic              run = 1'h0, stall = 1'h0, loose = 1'h0, ing_q = 1'h0, eg_q = 1'h0;
    logic              lr = 1'h0, lf = 1'h0, tf_l = 1'h0, pend_v = 1'h0, pend_oe = 1'h1;
    logic [6:0]        mode = 7'h00;
    logic [6:0]        modes [3] = '{7'h43, 7'h4B, 7'h5F};
    logic [1:0]        exp_q [$];
    int                errors = 0, samples_checked = 0, cycles = 0, pend = 0, seed = 48742;

    always #2.5 ref_clk_i = ~ref_clk_i;

    degc_cell u_dut (
        .ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
        .avs_waitrequest_o, .ingress_reg_clk_i, .egress_reg_clk_i, .tx_bit_rise_i, .tx_bit_fall_i,
        .drive_enable_i, .rx_ready_i, .rx_bit_rise_o, .rx_bit_fall_o, .rx_valid_o, .bypass_input_tap_o,
        .pad_in_i, .pad_out_o, .pad_oe_n_o, .pad_pull_up_o, .pad_pull_down_o
    );

    degc_core_model u_core (
        .ref_clk_i, .rst_i, .run_i(run), .stall_i(stall), .ingress_clk_o(ingress_reg_clk_i),
        .egress_clk_o(egress_reg_clk_i), .tx_rise_o(tx_bit_rise_i), .tx_fall_o(tx_bit_fall_i),
        .drive_en_o(drive_enable_i), .rx_ready_o(rx_ready_i)
    );

    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'h0);
        rd = avs_readdata_o;
        avs_write_i <= 1'h0;
        avs_read_i  <= 1'h0;
        @(posedge ref_clk_i);
    endtask

    task automatic do_reset();
        rst_i <= 1'h1;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        exp_q.delete();
        @(posedge ref_clk_i);
    endtask

    // ------------------------------
    // pad stimulus and prediction
    // ------------------------------
    always @(posedge ref_clk_i) begin
        pad_in_i <= ($random(seed) & 1) != 0;
        ing_q    <= ingress_reg_clk_i;
        eg_q     <= egress_reg_clk_i;
        if (++cycles == 20000) begin
            errors++;
            give_verdict();
        end
        if (pend > 0 && --pend == 0) begin
            check(pad_out_o, pend_v);
            check(pad_oe_n_o, pend_oe);
        end
        if (rst_i) begin
            lr <= 1'h0;
            lf <= 1'h0;
        end else if (ingress_reg_clk_i != ing_q && mode[0]) begin
            if (ingress_reg_clk_i) begin
                lr <= pad_in_i;
                if (!loose) exp_q.push_back({mode[3] ? lf : 1'h0, pad_in_i});
            end else if (mode[3]) begin
                lf <= pad_in_i;
                if (!mode[4] && !loose) exp_q.push_back({pad_in_i, lr});
            end
        end
        if (!rst_i && egress_reg_clk_i != eg_q && mode[1]) begin
            if (egress_reg_clk_i) tf_l <= tx_bit_fall_i;
            if (egress_reg_clk_i || !mode[2]) pend_oe = !drive_enable_i;
            if (egress_reg_clk_i || mode[3]) begin
                pend   = 2;
                pend_v = egress_reg_clk_i ? tx_bit_rise_i : (mode[4] ? tf_l : tx_bit_fall_i);
            end
        end
    end

    always @(posedge ref_clk_i) begin
        if (!rst_i && !loose && rx_valid_o === 1'h1 && rx_ready_i === 1'h1) begin
            if (exp_q.size() > 0) check({rx_bit_fall_o, rx_bit_rise_o}, exp_q.pop_front());
            else check(1'h1, 1'h0);
        end
    end

    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        do_reset();
        bus(1'h0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0);
        bus(1'h1, CTRL_OFFSET, 32'hFFFF_FF80);
        bus(1'h0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0);
        bus(1'h1, 4'h8, 32'hFFFF_FFFF);
        bus(1'h0, 4'h8, 32'h0);
        check(rd, 32'h0);
        bus(1'h0, STATUS_OFFSET, 32'h0);
        check(rd[3:2], 2'h1);
        bus(1'h1, CTRL_OFFSET, 32'h60);
        repeat (4) @(posedge ref_clk_i);
        check(pad_pull_down_o, !drive_enable_i);
        check(pad_pull_up_o, 1'h0);
        foreach (modes[i]) begin
            do_reset();
            bus(1'h1, CTRL_OFFSET, {25'h0, modes[i]});
            mode = modes[i];
            run <= 1'h1;
            repeat (400) @(posedge ref_clk_i);
            run <= 1'h0;
            repeat (40) @(posedge ref_clk_i);
            check(exp_q.size(), 32'h0);
        end
        do_reset();
        bus(1'h1, CTRL_OFFSET, 32'h41);
        mode = 7'h41;
        loose = 1'h1;
        stall <= 1'h1;
        run <= 1'h1;
        repeat (200) @(posedge ref_clk_i);
        run <= 1'h0;
        bus(1'h0, STATUS_OFFSET, 32'h0);
        check(rd[8:1], 8'h83);
        stall <= 1'h0;
        repeat (100) @(posedge ref_clk_i);
        bus(1'h1, STATUS_OFFSET, 32'h2);
        bus(1'h0, STATUS_OFFSET, 32'h0);
        check(rd[8:1], 8'h02);
        give_verdict();
    end

endmodule // test_dual_edge_gpio_cell

`default_nettype wire
